// file: csmu_pkg.sv
// constants, types and helpers shared by the character move unit
package csmu_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] CSMU_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSMU_OFF_STAT = 8'h04;
  localparam logic [7:0] CSMU_OFF_GPR  = 8'h20;

  // control register bit positions (write-one pulses)
  localparam int CSMU_CTRL_START_REG = 0;
  localparam int CSMU_CTRL_START_INL = 1;
  localparam int CSMU_CTRL_RESUME    = 2;

  // status register bit positions
  localparam int CSMU_STAT_BUSY = 0;
  localparam int CSMU_STAT_DONE = 1;
  localparam int CSMU_STAT_SUSP = 2;
  localparam int CSMU_STAT_CC   = 3;

  // general register numbers used by the move
  localparam logic [2:0] CSMU_GPR_PC   = 3'h7;
  localparam logic [2:0] CSMU_GPR_FILL = 3'h4;

  // memory stepping and in-line fetch sequence
  localparam logic [15:0] CSMU_WORD_STEP  = 16'h0002;
  localparam logic [2:0]  CSMU_FETCH_OPS  = 3'h3;
  localparam logic [2:0]  CSMU_FETCH_LAST = 3'h6;

  // register reset value and the high byte put above each character
  localparam logic [15:0] CSMU_GPR_RST  = 16'h0000;
  localparam logic [7:0]  CSMU_FILL_HI  = 8'h00;

  // engine states
  typedef enum logic [2:0] {
    CSMU_IDLE  = 3'b000,
    CSMU_FETCH = 3'b001,
    CSMU_SETUP = 3'b010,
    CSMU_DISP  = 3'b011,
    CSMU_COPY  = 3'b100,
    CSMU_FILL  = 3'b101,
    CSMU_SUSP  = 3'b110,
    CSMU_FIN   = 3'b111
  } csmu_state_e;

  // condition codes
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } csmu_cc_s;

  // memory bus request
  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_sel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csmu_mreq_s;

  // smaller of two unsigned lengths
  function automatic logic [15:0] csmu_min16(input logic [15:0] a, input logic [15:0] b);
    csmu_min16 = (a < b) ? a : b;
  endfunction

  // address step up or down by one byte
  function automatic logic [15:0] csmu_step(input logic [15:0] a, input logic down);
    csmu_step = down ? 16'(a - 16'h0001) : 16'(a + 16'h0001);
  endfunction

endpackage

// file: csmu_cc.sv
// condition code generator from the two initial lengths
`timescale 1ns/100ps
`default_nettype none
module csmu_cc import csmu_pkg::*; (
  // lengths
  input  wire logic [15:0] src_len,
  input  wire logic [15:0] dst_len,
  // flags
  output csmu_cc_s         cc
);
  logic [16:0] diff;
  logic [15:0] res;

  // src minus dst with carry out of bit 15
  assign diff = {1'b0, src_len} + {1'b0, ~dst_len} + 17'h00001;
  assign res  = diff[15:0];

  // flag derivation
  assign cc.n = res[15];
  assign cc.z = (res == 16'h0000);
  assign cc.v = (src_len[15] != dst_len[15]) && (dst_len[15] == res[15]);
  assign cc.c = ~diff[16];
endmodule
`default_nettype wire

// file: csmu_buf2.sv
// small ready/valid buffer in the character path
`timescale 1ns/100ps
`default_nettype none
module csmu_buf2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_q [0:D-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  // honest full and empty
  assign in_ready  = (cnt_q != CW'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : AW'(rp_q + 1'b1);
      end
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end
endmodule
`default_nettype wire

// file: csmu_move_unit.sv
// character string move engine with apb register access and memory master
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - flags compare src length minus dst length; N if negative, Z if zero.
// - V set when length sign bits differ and dst sign equals result sign.
// - C is borrow: cleared on carry out of bit 15, else set.
// - string aligned at lowest address; short source padded at high addresses with fill.
// - long source truncated; only destination-length characters are copied.
// - register form ends with unmoved count in R0, zero, fill.
// - in-line form fetches three words after opcode, stepping PC by two.
// - descriptor is length word at pointer, address word at pointer plus two.
// - in-line form leaves R0-as found; only PC advances.
// - source at or above destination: copy upward, then fill upward.
// - source below destination: work downward, fill first, then copy downward.
// - move may suspend between characters, progress kept in general registers.
// - result equals reading whole source before writing any destination byte.
// - empty source fills all; empty destination writes nothing, still updates state.
module csmu_move_unit import csmu_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // memory master
  output csmu_mreq_s       mem_o,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // host core control
  input  wire logic        susp_req,
  output logic             busy
);
  csmu_state_e st_q;
  csmu_mreq_s  mreq_q;
  csmu_cc_s    cc_q;
  csmu_cc_s    cc_now;
  logic [15:0] gpr_q [0:7];
  logic [15:0] sh_q [0:4];
  logic [15:0] s_len_q;
  logic [15:0] s_adr_q;
  logic [15:0] d_len_q;
  logic [15:0] d_adr_q;
  logic [15:0] rd_left_q;
  logic [7:0]  fill_q;
  logic [2:0]  fidx_q;
  logic        dir_q;
  logic        inl_q;
  logic        done_q;
  logic        susp_q;
  logic [31:0] prdata_q;
  // apb decode
  logic        apb_setup;
  logic        apb_wr;
  logic        hit;
  logic        gpr_sel;
  logic [2:0]  gpr_idx;
  logic [31:0] rd_val;
  logic        cmd_reg;
  logic        cmd_inl;
  logic        cmd_res;
  // engine issue and buffer
  logic        iss;
  logic        iss_we;
  logic        iss_byte;
  logic [15:0] iss_addr;
  logic [15:0] iss_wdata;
  logic        acc_done;
  logic        rd_ack;
  logic        wr_ack;
  logic        need_fill;
  logic        buf_in_rdy;
  logic        buf_out_v;
  logic [7:0]  buf_out_d;
  logic        buf_push;
  logic        buf_pop;
  logic [15:0] min_len;
  // apb address decode and read mux
  assign apb_setup = psel & ~penable;
  assign gpr_sel   = (paddr[7:5] == CSMU_OFF_GPR[7:5]) && (paddr[1:0] == 2'b00);
  assign gpr_idx   = paddr[4:2];
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == CSMU_OFF_CTRL) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == CSMU_OFF_STAT) begin
      rd_val[CSMU_STAT_BUSY]              = busy;
      rd_val[CSMU_STAT_DONE]              = done_q;
      rd_val[CSMU_STAT_SUSP]              = susp_q;
      rd_val[CSMU_STAT_CC +: 4]           = cc_q;
    end else if (gpr_sel) begin
      rd_val[15:0] = gpr_q[gpr_idx];
    end else begin
      hit = 1'b0;
    end
  end
  // zero-wait answer; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;
  assign apb_wr  = psel & penable & pwrite & hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= rd_val;
    end
  end
  // start and resume commands, accepted only while idle
  assign busy    = (st_q != CSMU_IDLE);
  assign cmd_reg = apb_wr && (paddr == CSMU_OFF_CTRL) && !busy && pwdata[CSMU_CTRL_START_REG];
  assign cmd_inl = apb_wr && (paddr == CSMU_OFF_CTRL) && !busy && !pwdata[CSMU_CTRL_START_REG]
                   && pwdata[CSMU_CTRL_START_INL];
  assign cmd_res = apb_wr && (paddr == CSMU_OFF_CTRL) && !busy && susp_q
                   && !pwdata[CSMU_CTRL_START_REG] && !pwdata[CSMU_CTRL_START_INL]
                   && pwdata[CSMU_CTRL_RESUME];
  // flags from the lengths held at setup
  csmu_cc u_cc (
    .src_len (s_len_q),
    .dst_len (d_len_q),
    .cc      (cc_now)
  );
  // character buffer between memory reads and writes
  csmu_buf2 #(
    .W (8),
    .D (2)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (buf_push),
    .in_ready  (buf_in_rdy),
    .in_data   (mem_rdata[7:0]),
    .out_valid (buf_out_v),
    .out_ready (buf_pop),
    .out_data  (buf_out_d)
  );
  // access completion and buffer strobes
  assign acc_done  = mreq_q.req & mem_ack;
  assign rd_ack    = acc_done & ~mreq_q.we;
  assign wr_ack    = acc_done & mreq_q.we;
  assign buf_push  = rd_ack & (st_q == CSMU_COPY);
  assign buf_pop   = wr_ack & (st_q == CSMU_COPY);
  assign min_len   = csmu_min16(s_len_q, d_len_q);
  // downward pass fills while source is shorter; upward fills what is left
  assign need_fill = dir_q ? (s_len_q < d_len_q) : (d_len_q != 16'h0000);
  // memory access selection per state
  always_comb begin
    iss       = 1'b0;
    iss_we    = 1'b0;
    iss_byte  = 1'b0;
    iss_addr  = 16'h0000;
    iss_wdata = 16'h0000;
    case (st_q)
      CSMU_FETCH: begin
        iss = 1'b1;
        case (fidx_q)
          3'h3:    iss_addr = s_adr_q;
          3'h4:    iss_addr = 16'(s_adr_q + CSMU_WORD_STEP);
          3'h5:    iss_addr = d_adr_q;
          3'h6:    iss_addr = 16'(d_adr_q + CSMU_WORD_STEP);
          default: iss_addr = gpr_q[CSMU_GPR_PC];
        endcase
      end
      CSMU_COPY: begin
        iss_byte = 1'b1;
        if (rd_left_q != 16'h0000 && buf_in_rdy && !susp_req) begin
          iss      = 1'b1;
          iss_addr = s_adr_q;
        end else if (buf_out_v) begin
          iss       = 1'b1;
          iss_we    = 1'b1;
          iss_addr  = d_adr_q;
          iss_wdata = {CSMU_FILL_HI, buf_out_d};
        end
      end
      CSMU_FILL: begin
        iss_byte  = 1'b1;
        iss_we    = 1'b1;
        iss       = need_fill & ~susp_req;
        iss_addr  = d_adr_q;
        iss_wdata = {CSMU_FILL_HI, fill_q};
      end
      default: iss = 1'b0;
    endcase
  end
  // memory request register, held until acknowledged
  assign mem_o = mreq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mreq_q <= '0;
    end else if (!mreq_q.req && iss) begin
      mreq_q <= '{req: 1'b1, we: iss_we, byte_sel: iss_byte, addr: iss_addr, wdata: iss_wdata};
    end else if (acc_done) begin
      mreq_q.req <= 1'b0;
    end
  end

  // move sequencer and working descriptors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= CSMU_IDLE;
      s_len_q   <= CSMU_GPR_RST;
      s_adr_q   <= CSMU_GPR_RST;
      d_len_q   <= CSMU_GPR_RST;
      d_adr_q   <= CSMU_GPR_RST;
      rd_left_q <= CSMU_GPR_RST;
      fill_q    <= 8'h00;
      fidx_q    <= 3'h0;
      dir_q     <= 1'b0;
      inl_q     <= 1'b0;
      done_q    <= 1'b0;
      susp_q    <= 1'b0;
      cc_q      <= '0;
      for (int i = 0; i < 5; i++) begin
        sh_q[i] <= CSMU_GPR_RST;
      end
    end else begin
      case (st_q)
        CSMU_IDLE: begin
          if (cmd_reg || cmd_res) begin
            s_len_q <= gpr_q[0];
            s_adr_q <= gpr_q[1];
            d_len_q <= gpr_q[2];
            d_adr_q <= gpr_q[3];
            fill_q  <= gpr_q[CSMU_GPR_FILL][7:0];
            done_q  <= 1'b0;
            susp_q  <= 1'b0;
            st_q    <= cmd_res ? CSMU_DISP : CSMU_SETUP;
          end
          if (cmd_reg) begin
            inl_q <= 1'b0;
          end
          if (cmd_inl) begin
            inl_q  <= 1'b1;
            fidx_q <= 3'h0;
            done_q <= 1'b0;
            susp_q <= 1'b0;
            st_q   <= CSMU_FETCH;
            for (int i = 0; i < 5; i++) begin
              sh_q[i] <= gpr_q[i];
            end
          end
        end
        CSMU_FETCH: begin
          if (rd_ack) begin
            case (fidx_q)
              3'h0:    s_adr_q <= mem_rdata;
              3'h1:    d_adr_q <= mem_rdata;
              3'h2:    fill_q  <= mem_rdata[7:0];
              3'h3:    s_len_q <= mem_rdata;
              3'h4:    s_adr_q <= mem_rdata;
              3'h5:    d_len_q <= mem_rdata;
              default: d_adr_q <= mem_rdata;
            endcase
            fidx_q <= 3'(fidx_q + 3'h1);
            if (fidx_q == CSMU_FETCH_LAST) begin
              st_q <= CSMU_SETUP;
            end
          end
        end
        CSMU_SETUP: begin
          cc_q  <= cc_now;
          dir_q <= (s_adr_q < d_adr_q);
          if (s_adr_q < d_adr_q) begin
            s_adr_q <= 16'(s_adr_q + min_len - 16'h0001);
            d_adr_q <= 16'(d_adr_q + d_len_q - 16'h0001);
          end
          st_q <= CSMU_DISP;
        end
        CSMU_DISP: begin
          rd_left_q <= min_len;
          st_q      <= dir_q ? CSMU_FILL : CSMU_COPY;
        end
        CSMU_COPY: begin
          if (rd_ack) begin
            s_len_q   <= 16'(s_len_q - 16'h0001);
            s_adr_q   <= csmu_step(s_adr_q, dir_q);
            rd_left_q <= 16'(rd_left_q - 16'h0001);
          end
          if (wr_ack) begin
            d_len_q <= 16'(d_len_q - 16'h0001);
            d_adr_q <= csmu_step(d_adr_q, dir_q);
          end
          if (!mreq_q.req && !buf_out_v) begin
            if (rd_left_q == 16'h0000) begin
              st_q <= dir_q ? CSMU_FIN : CSMU_FILL;
            end else if (susp_req) begin
              st_q <= CSMU_SUSP;
            end
          end
        end
        CSMU_FILL: begin
          if (wr_ack) begin
            d_len_q <= 16'(d_len_q - 16'h0001);
            d_adr_q <= csmu_step(d_adr_q, dir_q);
          end else if (!mreq_q.req) begin
            if (!need_fill) begin
              rd_left_q <= d_len_q;
              st_q      <= dir_q ? CSMU_COPY : CSMU_FIN;
            end else if (susp_req) begin
              st_q <= CSMU_SUSP;
            end
          end
        end
        CSMU_SUSP: begin
          susp_q <= 1'b1;
          st_q   <= CSMU_IDLE;
        end
        CSMU_FIN: begin
          done_q <= 1'b1;
          st_q   <= CSMU_IDLE;
        end
        default: st_q <= CSMU_IDLE;
      endcase
    end
  end

  // general register image: software loads, engine writes back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= CSMU_GPR_RST;
      end
    end else begin
      case (st_q)
        CSMU_IDLE: begin
          if (apb_wr && gpr_sel) begin
            gpr_q[gpr_idx] <= pwdata[15:0];                     // ignored while busy
          end
        end
        CSMU_FETCH: begin
          if (rd_ack && fidx_q < CSMU_FETCH_OPS) begin
            gpr_q[CSMU_GPR_PC] <= 16'(gpr_q[CSMU_GPR_PC] + CSMU_WORD_STEP);
          end
        end
        CSMU_SUSP: begin
          gpr_q[0]             <= s_len_q;
          gpr_q[1]             <= s_adr_q;
          gpr_q[2]             <= d_len_q;
          gpr_q[3]             <= d_adr_q;
          gpr_q[CSMU_GPR_FILL] <= {CSMU_FILL_HI, fill_q};
        end
        CSMU_FIN: begin
          if (inl_q) begin
            for (int i = 0; i < 5; i++) begin
              gpr_q[i] <= sh_q[i];
            end
          end else begin
            gpr_q[0]             <= s_len_q;
            gpr_q[1]             <= CSMU_GPR_RST;
            gpr_q[2]             <= CSMU_GPR_RST;
            gpr_q[3]             <= CSMU_GPR_RST;
            gpr_q[CSMU_GPR_FILL] <= {CSMU_FILL_HI, fill_q};
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: csmu_mem_model.sv
// byte memory that answers the move unit, at once or after three wait cycles
`timescale 1ns/100ps
`default_nettype none
module csmu_mem_model import csmu_pkg::*; (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request and pace
  input  wire csmu_mreq_s mem_o,
  input  wire logic       slow,
  // answer
  output logic            mem_ack,
  output logic [15:0]     mem_rdata
);
  logic [7:0]  m [0:65535];
  logic [1:0]  wait_q;
  logic [15:0] a;

  assign a = mem_o.addr;

  // ack and read data; the data lines toggle whenever nothing is answered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_o.req && !mem_ack && (!slow || wait_q == 2'h3)) begin
      mem_ack   <= 1'b1;
      wait_q    <= 2'h0;
      mem_rdata <= {mem_o.byte_sel ? ~m[a] : m[16'(a + 16'h0001)], m[a]};
    end else begin
      mem_ack   <= 1'b0;
      wait_q    <= (mem_o.req && !mem_ack) ? 2'(wait_q + 2'h1) : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end

  // a write lands only at the edge that completes it
  always @(posedge pclk) begin
    if (mem_o.req && mem_ack && mem_o.we) begin
      m[a] <= mem_o.wdata[7:0];
    end
  end
endmodule
`default_nettype wire

// file: csmu_move_unit_sva.sv
// port checker for the character move unit
`timescale 1ns/100ps
`default_nettype none
module csmu_move_unit_sva import csmu_pkg::*; (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory and core
  input wire csmu_mreq_s  mem_o,
  input wire logic        mem_ack,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decoded access phase and address map
  logic acc;
  logic mapped;
  assign acc    = psel && penable;
  assign mapped = (paddr == CSMU_OFF_CTRL) || (paddr == CSMU_OFF_STAT) ||
                  (paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0);

  // accepted start command of either form
  sequence s_start(logic [1:0] c);
    acc && pwrite && paddr == CSMU_OFF_CTRL && pwdata[1:0] == c && !busy;
  endsequence
  // first operand fetch of the in-line form
  sequence s_word_read;
    mem_o.req && !mem_o.we && !mem_o.byte_sel;
  endsequence

  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_slverr_map: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_req_holds: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o))
    else $error("memory request changed before ack");
  a_req_drops: assert property (mem_o.req && mem_ack |=> !mem_o.req)
    else $error("memory request not dropped after ack");
  a_write_byte: assert property (mem_o.req && mem_o.we |-> mem_o.byte_sel && mem_o.wdata[15:8] == 8'h00)
    else $error("character write not a byte write");
  a_idle_quiet: assert property (!busy |-> !mem_o.req)
    else $error("memory request while not busy");
  a_reg_start: assert property (s_start(2'h1) |=> busy [*2])
    else $error("register form start not taken");
  a_inl_fetch: assert property (s_start(2'h2) |-> ##[1:4] s_word_read)
    else $error("in-line form did not fetch a word");
endmodule

bind csmu_move_unit csmu_move_unit_sva chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .mem_o, .mem_ack, .busy
);
`default_nettype wire

// file: tb_top.sv
// self-checking bench: register and in-line moves against a memory model
`timescale 1ns/100ps
`default_nettype none
module tb_top import csmu_pkg::*; ();
  logic        pclk, presetn, psel, penable, pwrite, susp_req, slow;
  logic        pready, pslverr, mem_ack, busy, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] mem_rdata;
  csmu_mreq_s  mem_o;
  logic [7:0]  srcb [0:15];
  int          fail_count, comparisons;

  // design and far-side memory
  csmu_move_unit dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_o, .mem_ack, .mem_rdata, .susp_req, .busy
  );
  csmu_mem_model mem (.pclk, .presetn, .mem_o, .slow, .mem_ack, .mem_rdata);

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // one apb transfer, held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // expected flags {n,z,v,c} of the length comparison
  function automatic logic [3:0] ccx(input logic [15:0] s, input logic [15:0] d);
    logic [15:0] t;
    t = s - d;
    return {t[15], t == 16'h0000, (s[15] != d[15]) && (d[15] == t[15]), s < d};
  endfunction

  // one move: preload, start, maybe suspend and resume, then compare all; a suspended move with dl bit 15 set is checked while held, not resumed
  task automatic mv(input string nm, input logic [15:0] sl, sa, dl, da,
                    input logic [7:0] f, input logic inl, input logic sp);
    logic [15:0] pre [0:7];
    logic [15:0] ex [0:7];
    logic [7:0]  g0, g1;
    logic [15:0] r;
    slow <= sp;
    for (int i = 0; i < 16; i++) begin
      srcb[i] = 8'h61 + 8'(i) + sa[7:0];
      if (i < sl) mem.m[sa + 16'(i)] = srcb[i];
    end
    g0  = mem.m[da - 16'h0001];
    g1  = mem.m[da + dl];
    pre = '{sl, sa, dl, da, {8'h00, f}, 16'h5555, 16'h6666, 16'h0800};
    ex  = '{(sl > dl) ? sl - dl : 16'h0000, 16'h0000, 16'h0000, 16'h0000, {8'h00, f},
            16'h5555, 16'h6666, 16'h0800};
    if (inl) begin
      pre = '{16'h1001, 16'h2002, 16'h3003, 16'h4004, 16'h5005, 16'h6006, 16'h7007, 16'h0800};
      ex  = '{16'h0806, 16'h080A, {8'h00, f}, sl, sa, dl, da, 16'h0000};
      for (int i = 0; i < 7; i++) begin
        mem.m[16'h0800 + 16'(2 * i)] = ex[i][7:0];
        mem.m[16'h0801 + 16'(2 * i)] = ex[i][15:8];
      end
      ex    = pre;
      ex[7] = 16'h0806;
    end
    for (int n = 0; n < 8; n++) xfer(1'b1, CSMU_OFF_GPR + 8'(4 * n), {16'h0000, pre[n]});
    xfer(1'b1, CSMU_OFF_CTRL, inl ? 32'h00000002 : 32'h00000001);
    if (sp) begin
      repeat (24) @(posedge pclk);
      susp_req <= 1'b1;
      do xfer(1'b0, CSMU_OFF_STAT, 32'h00000000); while (rdat[CSMU_STAT_SUSP] !== 1'b1);
      susp_req <= 1'b0;
      if (dl[15]) begin
        chk("held flags", {28'h0000000, ccx(sl, dl)}, {28'h0000000, rdat[6:3]});
        xfer(1'b0, CSMU_OFF_GPR + 8'h08, 32'h00000000);
        r = rdat[15:0];
        xfer(1'b0, CSMU_OFF_GPR + 8'h0C, 32'h00000000);
        chk("saved address", {16'h0000, 16'(da + dl - r)}, rdat);
        chk("first char", {24'h000000, srcb[0]}, {24'h000000, mem.m[da]});
        $display("test %s done", nm);
        return;
      end
      xfer(1'b1, CSMU_OFF_CTRL, 32'h00000004);
    end
    do xfer(1'b0, CSMU_OFF_STAT, 32'h00000000); while (rdat[CSMU_STAT_BUSY] !== 1'b0);
    chk("status", {25'h0, ccx(sl, dl), 3'h2}, rdat);
    chk("busy pin", 32'h00000000, {31'h0, busy});
    for (int n = 0; n < 8; n++) begin
      xfer(1'b0, CSMU_OFF_GPR + 8'(4 * n), 32'h00000000);
      chk("register", {16'h0000, ex[n]}, rdat);
    end
    for (int i = 0; i < dl; i++) begin
      chk("dest byte", {24'h000000, (i < sl) ? srcb[i] : f},
          {24'h000000, mem.m[da + 16'(i)]});
    end
    chk("below dest", {24'h000000, g0}, {24'h000000, mem.m[da - 16'h0001]});
    chk("above dest", {24'h000000, g1}, {24'h000000, mem.m[da + dl]});
    $display("test %s done", nm);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  // reset, register map checks, then the moves
  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h00000000;
    susp_req = 1'b0;
    slow     = 1'b0;
    for (int a = 0; a < 65536; a++) mem.m[a] = 8'(a * 7);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, CSMU_OFF_STAT, 32'h00000000);
    chk("status after reset", 32'h00000000, rdat);
    xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    xfer(1'b0, 8'h10, 32'h00000000);
    chk("unmapped error", 32'h00000001, {31'h0, last_err});
    chk("unmapped data", 32'h00000000, rdat);
    $display("test register map done");
    mv("up fill", 16'h0003, 16'h0200, 16'h0006, 16'h0100, 8'h20, 1'b0, 1'b0);
    mv("down trunc", 16'h0005, 16'h0300, 16'h0004, 16'h0302, 8'h2A, 1'b0, 1'b0);
    mv("down fill", 16'h0002, 16'h0400, 16'h0006, 16'h0401, 8'h2B, 1'b0, 1'b1);
    mv("equal", 16'h0004, 16'h0500, 16'h0004, 16'h0480, 8'h2C, 1'b0, 1'b0);
    mv("empty src", 16'h0000, 16'h0200, 16'h0004, 16'h0210, 8'h00, 1'b0, 1'b0);
    mv("empty dst", 16'h0005, 16'h0200, 16'h0000, 16'h0220, 8'h2D, 1'b0, 1'b0);
    mv("inline", 16'h0002, 16'h0120, 16'h0003, 16'h0110, 8'h2E, 1'b1, 1'b0);
    mv("inline overlap", 16'h0006, 16'h0131, 16'h0004, 16'h0130, 8'h21, 1'b1, 1'b0);
    mv("long held", 16'h0001, 16'h0600, 16'h8000, 16'h0500, 8'h2F, 1'b0, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
